// ---- design/smrc_pkg.sv ----
package smrc_pkg;
	// starter type selection codes
	localparam logic [1:0] TYPE_SOLID = 2'h0;
	localparam logic [1:0] TYPE_WYE_DELTA = 2'h1;
	localparam logic [1:0] TYPE_FULL_VOLTAGE = 2'h2;
	// wye-delta transition thresholds in percent
	localparam int CURRENT_PCT = 85;
	localparam int ELAPSED_PCT = 25;
	// time base: one tick is 1 ms at 100 MHz
	localparam int CLOCK_MHZ = 100;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLOCK_MHZ * TICK_US;
	// widths of time settings in ticks and of current values
	localparam int TIME_W = 16;
	localparam int CUR_W = 16;
	localparam int GATE_W = 6;
	// fault cause codes
	localparam logic [1:0] FAULT_NONE = 2'h0;
	localparam logic [1:0] FAULT_FEEDBACK = 2'h1;
	localparam logic [1:0] FAULT_EXTERNAL = 2'h2;
endpackage

// ---- design/smrc_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// two flip-flop synchroniser for pin levels
module smrc_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// levels
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} smrc_sync_s;
	smrc_sync_s state;
	smrc_sync_s next_state;

	// first stage is read only by the second stage
	always_comb begin
		next_state.first = pinIn;
		next_state.second = state.first;
	end

	// register both stages
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pinOut = state.second;
endmodule
`default_nettype wire

// ---- design/smrc_tick.sv ----
`timescale 1ns/10ps
`default_nettype none
// free running divider giving a one cycle tick
module smrc_tick #(
	parameter int CYCLES = smrc_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// tick out
	output logic tick
);
	localparam int CW = $clog2(CYCLES + 1);
	typedef struct packed {
		logic [CW-1:0] count;
		logic pulse;
	} smrc_tick_s;
	smrc_tick_s state;
	smrc_tick_s next_state;

	initial begin
		if (CYCLES < 1) begin
			$error("tick divider needs at least one cycle");
		end
	end

	// count down, pulse on wrap
	always_comb begin
		next_state = state;
		next_state.pulse = 1'b0;
		if (state.count == '0) begin
			next_state.count = CW'(CYCLES - 1);
			next_state.pulse = 1'b1;
		end else begin
			next_state.count = state.count - 1'b1;
		end
	end

	// register divider state
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign tick = state.pulse;
endmodule
`default_nettype wire

// ---- design/smrc_run_control.sv ----
`timescale 1ns/10ps
`default_nettype none
// Function
// - full-voltage mode drives external contactor directly
// - full-voltage start energizes run relay
// - full-voltage at speed energizes at-speed relay
// - full-voltage excludes thyristor and stack protections
// - ramp, kick, decel ignored in contactor modes
// - wye-delta mode holds gate outputs off
// - full-voltage mode holds gate outputs off
// - delta feedback unconfirmed in time trips
// - two-wire runs while start input present
// - three-wire runs from pulse until stop low
// - three-wire only if stop high at start
// - three-wire start is sealed in internally
// - delta at current drop past a quarter of the time, or at full time
// - wye on run relay, delta adds at-speed
module smrc_run_control #(
	parameter int TICK_CYCLES = smrc_pkg::TICK_CYCLES,
	parameter int TIME_W = smrc_pkg::TIME_W,
	parameter int CUR_W = smrc_pkg::CUR_W,
	parameter int GATE_W = smrc_pkg::GATE_W
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// configuration
	input wire logic [1:0] starterType,
	input wire logic stopAssigned,
	input wire logic feedbackAssigned,
	input wire logic [TIME_W-1:0] atSpeedTime,
	input wire logic [TIME_W-1:0] feedbackTime,
	input wire logic [CUR_W-1:0] ratedMotorCurrent,
	// measurement and protection from same clock domain
	input wire logic [CUR_W-1:0] motorCurrent,
	input wire logic protectionFault,
	input wire logic thyristorFault,
	input wire logic stackOverload,
	input wire logic faultReset,
	// solid state gate requests, passed only in solid state type
	input wire logic [GATE_W-1:0] gateRequest,
	input wire logic rampActive,
	// pins
	input wire logic startPin,
	input wire logic stopPin,
	input wire logic deltaFeedbackPin,
	// relays and gates
	output logic mainRelay,
	output logic atSpeedRelay,
	output logic [GATE_W-1:0] gateDrive,
	output logic rampEnable,
	// status
	output logic running,
	output logic threeWire,
	output logic tripped,
	output logic [1:0] faultCause
);
	initial begin
		if (TIME_W < 4 || CUR_W < 4 || TICK_CYCLES < 1) begin
			$error("unsupported width or tick setting");
		end
	end

	// run sequencing states
	// idle waits for a start edge, wye and delta are the two contactor steps,
	// run covers full voltage and solid state once started, and trip holds
	// everything off until an operator reset
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WYE = 5'h02,
		ST_DELTA = 5'h04,
		ST_RUN = 5'h08,
		ST_TRIP = 5'h10
	} smrc_state_e;

	// all sequencer state lives in one record so that one process computes it
	// and one process registers it; the timers count ticks, not clocks, so a
	// 16 bit field covers more than a minute at the default time base
	// the relay and gate fields are the outputs themselves, which keeps every
	// pin but running and tripped driven straight from a flip-flop with no decode glitches
	typedef struct packed {
		smrc_state_e fsm;
		logic startPrev;
		logic sealed;
		logic threeWire;
		logic [TIME_W-1:0] timer;
		logic [TIME_W-1:0] fbTimer;
		logic fbWait;
		logic mainRelay;
		logic atSpeedRelay;
		logic [GATE_W-1:0] gates;
		logic rampEnable;
		logic [1:0] cause;
	} smrc_run_s;

	smrc_run_s state;
	smrc_run_s next_state;

	logic startSync; // synchronised start level
	logic stopSync; // synchronised stop level
	logic fbSync; // synchronised delta feedback level
	logic tick; // 1 ms time base
	logic startRise; // start input edge
	logic runCondition; // start still wanted
	logic anyFault; // fault feeding this block
	logic [CUR_W+7:0] curScaled; // current times 100
	logic [CUR_W+7:0] limitScaled; // rated times 85
	logic [TIME_W+7:0] elapsedScaled; // timer times 100
	logic [TIME_W+7:0] quarterScaled; // setting times 25

	// pins cross into the clock domain through two stages
	smrc_sync #(
		.WIDTH(3)
	) pinSync (
		.clock(clock),
		.nrst(nrst),
		.pinIn({startPin, stopPin, deltaFeedbackPin}),
		.pinOut({startSync, stopSync, fbSync})
	);

	smrc_tick #(
		.CYCLES(TICK_CYCLES)
	) timeBase (
		.clock(clock),
		.nrst(nrst),
		.tick(tick)
	);

	// true when the chosen type bypasses the thyristor stack
	function automatic logic contactorMode(input logic [1:0] kind);
		contactorMode = (kind == smrc_pkg::TYPE_WYE_DELTA) || (kind == smrc_pkg::TYPE_FULL_VOLTAGE);
	endfunction

	// edge of the synchronised start level; startPrev resets low, which is the
	// idle level of the pin, so no false start follows reset
	assign startRise = startSync && !state.startPrev;
	// the products are wide enough for full scale inputs, so none of them wraps
	// and the compares below stay exact at every setting
	// percent compares done with multiplies to avoid a divider
	assign curScaled = (CUR_W + 8)'(motorCurrent) * (CUR_W + 8)'(100);
	assign limitScaled = (CUR_W + 8)'(ratedMotorCurrent) * (CUR_W + 8)'(smrc_pkg::CURRENT_PCT);
	assign elapsedScaled = (TIME_W + 8)'(state.timer) * (TIME_W + 8)'(100);
	assign quarterScaled = (TIME_W + 8)'(atSpeedTime) * (TIME_W + 8)'(smrc_pkg::ELAPSED_PCT);

	// thyristor and stack faults only count when the stack is used
	always_comb begin
		anyFault = protectionFault;
		if (!contactorMode(starterType)) begin
			anyFault = protectionFault || thyristorFault || stackOverload;
		end
	end

	// run condition follows the chosen start/stop handling
	always_comb begin
		if (state.threeWire) begin
			runCondition = stopSync && (state.sealed || startSync);
		end else begin
			runCondition = startSync;
		end
	end

	// next state of the sequencer
	// the timer runs in every state, fbTimer only while fbWait; both saturate and are cleared where a step
	// begins, so a stale count from an earlier start can never act again
	// the trip and stop checks come after the case so they win over any step
	// taken in the same cycle
	always_comb begin
		next_state = state;
		next_state.startPrev = startSync;
		if (tick && state.timer != '1) begin
			next_state.timer = state.timer + 1'b1;
		end
		if (state.fbWait && tick && state.fbTimer != '1) begin
			next_state.fbTimer = state.fbTimer + 1'b1;
		end
		case (state.fsm)
			ST_IDLE: begin
				next_state.mainRelay = 1'b0;
				next_state.atSpeedRelay = 1'b0;
				next_state.sealed = 1'b0;
				next_state.fbWait = 1'b0;
				if (startRise && !anyFault) begin
					// wiring mode is picked at the start edge
					next_state.threeWire = stopAssigned && stopSync;
					next_state.sealed = stopAssigned && stopSync;
					next_state.timer = '0;
					// the run relay closes on start in every type, so the
					// at-speed relay is never energized without it
					next_state.mainRelay = 1'b1;
					// only wye-delta passes through the wye step first
					if (starterType == smrc_pkg::TYPE_WYE_DELTA) begin
						next_state.fsm = ST_WYE;
					end else begin
						next_state.fsm = ST_RUN;
					end
				end
			end
			ST_WYE: begin
				// the early step needs both a low current and a quarter of the
				// set time; the full time forces the step whatever the current
				// a limitation: the current is sampled each clock, unfiltered
				if (state.timer >= atSpeedTime ||
					(curScaled < limitScaled && elapsedScaled > quarterScaled)) begin
					next_state.atSpeedRelay = 1'b1;
					next_state.fbWait = feedbackAssigned;
					next_state.fbTimer = '0;
					next_state.fsm = ST_DELTA;
				end
			end
			ST_DELTA: begin
				// once confirmed the feedback is not watched again, so a contact
				// that chatters later does not trip a running motor
				if (state.fbWait && fbSync) begin
					next_state.fbWait = 1'b0;
				end
			end
			ST_RUN: begin
				// contactor or solid state: at speed after the timer
				if (state.timer >= atSpeedTime) begin
					next_state.atSpeedRelay = 1'b1;
				end
			end
			ST_TRIP: begin
				// stays tripped until reset with start released
				if (faultReset && !startSync) begin
					next_state.cause = smrc_pkg::FAULT_NONE;
					next_state.fsm = ST_IDLE;
				end
			end
			default: begin
				next_state.fsm = ST_IDLE;
			end
		endcase
		// feedback confirmation timeout
		// the transition resistors are only short time rated, so a delta
		// contactor that fails to close must drop the starter rather than
		// leave the resistors in circuit
		if (state.fsm == ST_DELTA && state.fbWait && !fbSync && state.fbTimer >= feedbackTime) begin
			next_state.cause = smrc_pkg::FAULT_FEEDBACK;
			next_state.fsm = ST_TRIP;
		end
		if (state.fsm != ST_IDLE && state.fsm != ST_TRIP) begin
			if (anyFault) begin
				next_state.cause = smrc_pkg::FAULT_EXTERNAL;
				next_state.fsm = ST_TRIP;
			end else if (!runCondition) begin
				next_state.fsm = ST_IDLE;
			end
		end
		if (next_state.fsm == ST_IDLE || next_state.fsm == ST_TRIP) begin
			next_state.mainRelay = 1'b0;
			next_state.atSpeedRelay = 1'b0;
			next_state.fbWait = 1'b0;
			next_state.sealed = 1'b0;
		end
		// gates and ramp only in solid state running
		// decided from the next state so the gates drop in the same edge as
		// the relays when a stop or a trip is taken
		if (contactorMode(starterType) || next_state.fsm != ST_RUN) begin
			next_state.gates = '0;
			next_state.rampEnable = 1'b0;
		end else begin
			next_state.gates = gateRequest;
			next_state.rampEnable = rampActive;
		end
	end

	// register everything
	// reset loads constants only; the one-hot idle code is the sole set bit
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= '{fsm: ST_IDLE, default: '0};
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from flip-flops
	// running and tripped are decodes of registered state and
	// so change only at clock edges
	assign mainRelay = state.mainRelay;
	assign atSpeedRelay = state.atSpeedRelay;
	assign gateDrive = state.gates;
	assign rampEnable = state.rampEnable;
	assign running = state.fsm == ST_WYE || state.fsm == ST_DELTA || state.fsm == ST_RUN;
	assign threeWire = state.threeWire;
	assign tripped = state.fsm == ST_TRIP;
	assign faultCause = state.cause;
endmodule
`default_nettype wire

// ---- verification/smrc_contactor_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// delta contactor whose aux contact closes two cycles after its coil
module smrc_contactor_model (
	// clock
	input wire logic clock,
	// coil and failure control
	input wire logic coil,
	input wire logic stuck,
	// aux contact, low while open
	output logic closed
);
	logic [1:0] pull = 2'h0; // pull-in delay stages
	// a stuck contactor never closes, so its start has to trip
	always @(posedge clock) begin
		pull <= {pull[0], coil && !stuck};
	end
	assign closed = pull[1];
endmodule
`default_nettype wire

// ---- verification/smrc_run_control_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
// watches relay, gate and mode outputs of the run control
module smrc_run_control_chk #(
	parameter int GATE_W = smrc_pkg::GATE_W
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// configuration and pins
	input wire logic [1:0] starterType,
	input wire logic stopAssigned,
	input wire logic feedbackAssigned,
	input wire logic startPin,
	input wire logic stopPin,
	// outputs
	input wire logic mainRelay,
	input wire logic atSpeedRelay,
	input wire logic [GATE_W-1:0] gateDrive,
	input wire logic rampEnable,
	input wire logic threeWire,
	input wire logic tripped,
	input wire logic [1:0] faultCause
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	gate_off_a: assert property ($past(starterType) inside {2'h1, 2'h2} |-> gateDrive == '0)
		else $error("gate drive in contactor mode");
	ramp_off_a: assert property ($past(starterType) inside {2'h1, 2'h2} |-> !rampEnable)
		else $error("ramp enabled in contactor mode");
	start_lat_a: assert property ($rose(mainRelay) |-> $past(startPin, 2))
		else $error("run relay without start");
	relay_pair_a: assert property (atSpeedRelay |-> mainRelay)
		else $error("at-speed relay alone");
	trip_drop_a: assert property (tripped && $past(tripped) |-> !mainRelay && !atSpeedRelay)
		else $error("relay held while tripped");
	two_wire_a: assert property ((!startPin && !threeWire) [*5] |-> !mainRelay)
		else $error("two-wire run without start");
	three_stop_a: assert property (threeWire && $fell(stopPin) |-> ##[1:5] !mainRelay)
		else $error("three-wire run past stop");
	three_sel_a: assert property ($rose(threeWire) |-> stopAssigned && $past(stopPin, 2))
		else $error("three-wire without stop high");
	fb_cause_a: assert property ($rose(faultCause == 2'h1) |-> feedbackAssigned)
		else $error("feedback trip while unused");
	// main scenarios reached
	cover property (mainRelay && atSpeedRelay);
	cover property (threeWire && mainRelay);
	cover property ($rose(tripped));
endmodule
bind smrc_run_control smrc_run_control_chk #(.GATE_W(GATE_W)) i_smrc_run_control_chk (.clock(clock), .nrst(nrst),
	.starterType(starterType), .stopAssigned(stopAssigned), .feedbackAssigned(feedbackAssigned),
	.startPin(startPin), .stopPin(stopPin), .mainRelay(mainRelay), .atSpeedRelay(atSpeedRelay),
	.gateDrive(gateDrive), .rampEnable(rampEnable), .threeWire(threeWire), .tripped(tripped),
	.faultCause(faultCause));
`default_nettype wire

// ---- verification/starter_mode_run_control_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// random and corner scenarios for the run control
module starter_mode_run_control_tb;
	localparam int TC = 4; // short tick keeps the run brief
	localparam int AST = 16; // at-speed time in ticks
	localparam int FBT = 4; // feedback time in ticks
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] starterType = 2'h2;
	logic stopAssigned = 1'b1;
	logic feedbackAssigned = 1'b0;
	logic stuck = 1'b0; // forces the delta contact to fail
	logic [15:0] rated = 16'h0100;
	logic [15:0] cur = 16'h0100;
	logic thyristorFault = 1'b1;
	logic stackOverload = 1'b1;
	logic faultReset = 1'b0;
	logic protFault = 1'b0; // external protection fault
	logic [5:0] gateRequest = 6'h00;
	logic startPin = 1'b0;
	logic stopPin = 1'b0;
	logic [7:0] lf = 8'h62; // lfsr state, seed 98
	wire logic fb, mainRelay, atSpeedRelay, rampEnable, running, threeWire, tripped;
	wire logic [5:0] gateDrive;
	wire logic [1:0] faultCause;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	smrc_run_control #(.TICK_CYCLES(TC)) i_smrc_run_control (.clock(clock), .nrst(nrst),
		.starterType(starterType), .stopAssigned(stopAssigned), .feedbackAssigned(feedbackAssigned),
		.atSpeedTime(16'(AST)), .feedbackTime(16'(FBT)), .ratedMotorCurrent(rated), .motorCurrent(cur),
		.protectionFault(protFault), .thyristorFault(thyristorFault), .stackOverload(stackOverload),
		.faultReset(faultReset), .gateRequest(gateRequest), .rampActive(1'b1), .startPin(startPin),
		.stopPin(stopPin), .deltaFeedbackPin(fb), .mainRelay(mainRelay), .atSpeedRelay(atSpeedRelay),
		.gateDrive(gateDrive), .rampEnable(rampEnable), .running(running), .threeWire(threeWire),
		.tripped(tripped), .faultCause(faultCause));
	smrc_contactor_model i_smrc_contactor_model (.clock(clock), .coil(atSpeedRelay), .stuck(stuck), .closed(fb));
	always #5 clock = ~clock;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// ticks after which the early delta step is allowed
	function automatic int early(input int t);
		return t * smrc_pkg::ELAPSED_PCT / 100 + 1;
	endfunction
	// a current just under the transition threshold
	function automatic logic [15:0] low_cur(input logic [15:0] r);
		return 16'(r * smrc_pkg::CURRENT_PCT / 100 - 1);
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wc(input int n);
		repeat (n) @(negedge clock);
	endtask
	// start edge, then wait out sync and register
	task automatic start();
		startPin = 1'b1;
		wc(4);
	endtask
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// random gate requests change on the falling edge
	always @(negedge clock) begin
		lf = lfsr(lf);
		gateRequest = lf[5:0];
	end
	// hang guard, far above the expected few hundred cycles
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_errors++;
			stop_test();
		end
	end
	initial begin
		wc(4);
		nrst = 1'b1;
		// full voltage, two-wire with stop low, stack faults present
		start();
		chk(mainRelay, 1'b1);
		chk(running, 1'b1);
		chk(threeWire, 1'b0);
		chk(gateDrive, 6'h00);
		chk(rampEnable, 1'b0);
		wc((AST - 2) * TC);
		chk(atSpeedRelay, 1'b0);
		wc(4 * TC);
		chk(atSpeedRelay, 1'b1);
		chk(tripped, 1'b0);
		startPin = 1'b0;
		wc(4);
		chk(mainRelay, 1'b0);
		chk(atSpeedRelay, 1'b0);
		chk(running, 1'b0);
		// wye-delta, three-wire pulse, low current, good feedback
		starterType = 2'h1;
		feedbackAssigned = 1'b1;
		stopPin = 1'b1;
		cur = low_cur(rated);
		wc(4);
		start();
		startPin = 1'b0;
		wc(2 * TC);
		chk(atSpeedRelay, 1'b0);
		chk(threeWire, 1'b1);
		chk(mainRelay, 1'b1);
		chk(gateDrive, 6'h00);
		wc((early(AST) + 2) * TC);
		chk(atSpeedRelay, 1'b1);
		chk(mainRelay, 1'b1);
		wc((FBT + 2) * TC);
		chk(tripped, 1'b0);
		stopPin = 1'b0;
		wc(4);
		chk(mainRelay, 1'b0);
		// wye-delta, no stop input, delta contact stuck open
		stopAssigned = 1'b0;
		cur = rated;
		stuck = 1'b1;
		start();
		wc((AST + FBT + 2) * TC);
		chk(tripped, 1'b1);
		chk(faultCause, 2'h1);
		chk(mainRelay, 1'b0);
		startPin = 1'b0;
		wc(4);
		start();
		chk(mainRelay, 1'b0);
		startPin = 1'b0;
		faultReset = 1'b1;
		wc(4);
		faultReset = 1'b0;
		chk(tripped, 1'b0);
		// solid state passes gates and ramp, unlike contactor modes
		stuck = 1'b0;
		thyristorFault = 1'b0;
		stackOverload = 1'b0;
		starterType = 2'h0;
		feedbackAssigned = 1'b0;
		start();
		@(posedge clock);
		#1;
		chk(gateDrive, gateRequest);
		chk(rampEnable, 1'b1);
		chk(mainRelay, 1'b1);
		// a protection fault drops relays and gates at the next edge
		wc(1);
		protFault = 1'b1;
		wc(2);
		chk(tripped, 1'b1);
		chk(faultCause, 2'h2);
		chk(mainRelay, 1'b0);
		chk(gateDrive, 6'h00);
		chk(running, 1'b0);
		protFault = 1'b0;
		startPin = 1'b0;
		wc(4);
		stop_test();
	end
endmodule
`default_nettype wire
